// ==== card16_socket_defs.vh ====
`ifndef CARD16_SOCKET_DEFS_VH
`define CARD16_SOCKET_DEFS_VH

// ==========================================================
// Register indices, byte address is four times the index
`define IDX_IDENTITY      12'h800
`define IDX_STATUS        12'h801
`define IDX_POWER         12'h802
`define IDX_IRQ_GENERAL   12'h803
`define IDX_CHANGE        12'h804
`define IDX_CHANGE_CFG    12'h805
`define IDX_GLOBAL        12'h81E
`define IDX_MISC1         12'h82F

// ==========================================================
// Identification fields
`define KIND_MEM_IO       2'h2
`define REVISION_CODE     4'h1

// ==========================================================
// Power control fields
`define PWR_DRIVE_BIT     7
`define PWR_ON_BIT        4
`define PWR_VPP_LSB       0

// ==========================================================
// Interrupt and general control fields
`define IGC_RING_BIT      7
`define IGC_RESET_BIT     6
`define IGC_IO_BIT        5
`define IGC_STEER_LSB     0

// ==========================================================
// Change bits
`define CHG_DETECT        3
`define CHG_READY         2
`define CHG_WARN          1
`define CHG_DEAD          0
`define CFG_ROUTE_LSB     4

// ==========================================================
// Global control and misc control
`define GLB_ACK_BIT       2
`define GLB_RW_MASK       8'h0F
`define MISC_3V3_BIT      0

// ==========================================================
// Reset values
`define RST_POWER         8'h00
`define RST_IRQ_GENERAL   8'h00
`define RST_CHANGE_CFG    8'h00
`define RST_GLOBAL        8'h00
`define RST_MISC1         1'b0

`endif

// ==== card16_socket_setup_regs.v ====
// Behaviour
// [R1] Identification bits 7-6 read 10b, memory plus I/O interface.
// [R2] Identification bits 3-0 give fixed revision; bits 5-4 read zero.
// [R3] Status bit 6 is one while either socket supply enable is asserted.
// [R4] Status bit 5 mirrors card ready input; one is ready.
// [R5] Status bit 4 mirrors write-protect input; it blocks no writes itself.
// [R6] Status bits 3-2 read inverse of the two card detect pins.
// [R7] Status bits 1-0 show battery levels; I/O mode bit 0 shows change input. The code reads bit 0 as zero while the ring bit is set.
// [R8] Power bit 7 zero tri-states card-side outputs; one drives them.
// [R9] Power bit 4 off releases supplies; on, misc bit 0 picks 3.3 V or 5 V.
// [R10] Power bits 1-0 decode programming-voltage enables; bits 3-2 ignored.
// [R11] I/O mode with ring bit set passes change line to ring output.
// [R12] Control bit 6 zero holds card reset until software writes one.
// [R13] Control bit 5 selects memory (0) or I/O (1) card mode.
// [R14] Control bits 3-0 steer card interrupt when bridge ISA enable is set.
// [R15] Change bits read zero and never set while their enable is zero.
// [R16] Explicit ack mode: writing one clears a change bit, zero keeps it.
// [R17] Change interrupt stays asserted until all change bits are zero.
// [R18] Read-ack mode: any read of change register clears all bits.
// [R19] No second interrupt edge while other events are pending.
// [R20] Detect change sets on any detect edge; clears with event flag write-back.
// [R21] Ready change sets on ready rising edge; always zero in I/O mode.
// [R22] Bits 1/0 set on battery warning/dead; I/O bit 0 on change input low.
// [R23] Global bit 2 selects write-one-to-clear (1) or clear-on-read (0).
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "card16_socket_defs.vh"

module card16_socket_setup_regs #(
    parameter [3:0] REVISION = `REVISION_CODE
) (
    input  wire        clk,
    input  wire        resetn,
    input  wire [13:0] addr,
    input  wire [7:0]  wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [7:0]  rdata_q,
    input  wire        detect_pin_a_n,
    input  wire        detect_pin_b_n,
    input  wire        ready_or_irq_in,
    input  wire        protect_or_width_in,
    input  wire        battery1_or_change_in,
    input  wire        battery2_in,
    input  wire        isa_irq_enable,
    input  wire        detect_event_clear,
    output reg         card_outputs_drive_q,
    output reg         card_reset_q,
    output reg         io_mode_q,
    output reg         supply_3v3_enable_n_q,
    output reg         supply_5v_enable_n_q,
    output reg         prog_volt_enable0_q,
    output reg         prog_volt_enable1_q,
    output reg         ring_output_n_q,
    output reg  [15:0] system_irq_line_q,
    output reg         change_inta_q,
    output reg         change_irq_q
);

    // ==========================================================
    // Functions
    function irq_code_valid;
        input [3:0] code;
        begin
            case (code)
                4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC, 4'hE, 4'hF: irq_code_valid = 1'b1;
                default: irq_code_valid = 1'b0;
            endcase
        end
    endfunction

    function [15:0] irq_onehot;
        input [3:0] code;
        input       active;
        begin
            irq_onehot = 16'h0000;
            if (active && irq_code_valid(code)) begin
                irq_onehot[code] = 1'b1;
            end
        end
    endfunction

    // ==========================================================
    // Register storage
    reg  [7:0]  power_q;
    reg  [7:0]  irq_general_q;
    reg  [7:0]  change_cfg_q;
    reg  [7:0]  global_q;
    reg         misc_3v3_q;
    reg  [3:0]  change_q;
    reg  [3:0]  change_d;
    reg  [1:0]  detect_prev_q;
    reg         ready_prev_q;
    reg  [1:0]  battery_prev_q;
    reg  [7:0]  rdata_d;

    wire [11:0] index    = addr[13:2];
    wire        io_mode  = irq_general_q[`IGC_IO_BIT];
    wire        ring_en  = irq_general_q[`IGC_RING_BIT];
    wire        ack_write = global_q[`GLB_ACK_BIT];
    wire [1:0]  detect_now  = {detect_pin_b_n, detect_pin_a_n};
    wire [1:0]  battery_now = {battery2_in, battery1_or_change_in};

    // ==========================================================
    // Supply decode
    reg         s3v3_n;
    reg         s5v_n;
    reg         vpp0;
    reg         vpp1;

    always @* begin
        s3v3_n = 1'b1;
        s5v_n  = 1'b1;
        vpp0   = 1'b0;
        vpp1   = 1'b0;
        // [R9] Supply select
        if (power_q[`PWR_ON_BIT]) begin
            s3v3_n = ~misc_3v3_q;
            s5v_n  = misc_3v3_q;
            // [R10] Vpp decode, bits 3-2 unused
            case (power_q[`PWR_VPP_LSB +: 2])
                2'h1:    vpp0 = 1'b1;
                2'h2:    vpp1 = 1'b1;
                2'h3:    vpp0 = 1'b1;
                default: vpp0 = 1'b0;
            endcase
        end
    end

    // [R3] Power flag from decoded enables
    wire power_on_flag = ~s3v3_n | ~s5v_n;

    // ==========================================================
    // Change events
    // Mode masks keep stale memory-mode flags from leaking into I/O mode
    // [R21] Ready masked in I/O mode
    // [R22] Dead/change bit masked while ring passes through
    wire [3:0] mode_mask = io_mode ? {1'b1, 1'b0, 1'b0, ~ring_en} : 4'hF;
    // [R15] Enable gates read value
    wire [3:0] change_vis = change_q & change_cfg_q[3:0] & mode_mask;

    wire ev_detect = detect_now != detect_prev_q;
    wire ev_ready  = ~io_mode & ready_or_irq_in & ~ready_prev_q;
    wire ev_warn   = ~io_mode & (battery_now == 2'h1) & (battery_prev_q != 2'h1);
    wire ev_dead   = io_mode ? (~ring_en & ~battery_now[0] & battery_prev_q[0])
                             : (~battery_now[0] & battery_prev_q[0]);

    wire sel_change = index == `IDX_CHANGE;

    always @* begin
        change_d = change_q;
        // [R18] Read clears all
        if (rd && sel_change && !ack_write) begin
            change_d = 4'h0;
        end
        // [R16] Write one clears
        // [R23] Ack style select
        if (wr && sel_change && ack_write) begin
            change_d = change_d & ~wdata[3:0];
        end
        // [R20] Event flag write-back
        if (detect_event_clear) begin
            change_d[`CHG_DETECT] = 1'b0;
        end
        // Set wins over any clear in the same cycle
        // [R20] Detect change set
        if (ev_detect) begin
            change_d[`CHG_DETECT] = 1'b1;
        end
        // [R21] Ready rising edge
        if (ev_ready) begin
            change_d[`CHG_READY] = 1'b1;
        end
        // [R22] Battery warning and dead
        if (ev_warn) begin
            change_d[`CHG_WARN] = 1'b1;
        end
        if (ev_dead) begin
            change_d[`CHG_DEAD] = 1'b1;
        end
        // [R15] Disabled sources never set
        change_d = change_d & change_cfg_q[3:0];
    end

    // ==========================================================
    // Read mux
    always @* begin
        rdata_d = 8'h00;
        case (index)
            // [R1] Kind field
            // [R2] Revision, reserved zero
            `IDX_IDENTITY:    rdata_d = {`KIND_MEM_IO, 2'h0, REVISION};
            `IDX_STATUS: begin
                // [R3] Power flag
                rdata_d[6] = power_on_flag;
                // [R4] Ready level
                rdata_d[5] = ready_or_irq_in;
                // [R5] Write-protect level, reported only
                rdata_d[4] = protect_or_width_in;
                // [R6] Inverted detect pins
                rdata_d[3:2] = ~detect_now;
                // [R7] Battery levels or change input
                if (io_mode) begin
                    rdata_d[0] = ring_en ? 1'b0 : battery1_or_change_in;
                end else begin
                    rdata_d[1:0] = battery_now;
                end
            end
            `IDX_POWER:       rdata_d = power_q & 8'h9F;
            `IDX_IRQ_GENERAL: rdata_d = irq_general_q;
            `IDX_CHANGE:      rdata_d = {4'h0, change_vis};
            `IDX_CHANGE_CFG:  rdata_d = change_cfg_q;
            `IDX_GLOBAL:      rdata_d = global_q & `GLB_RW_MASK;
            `IDX_MISC1:       rdata_d = {7'h00, misc_3v3_q};
            default:          rdata_d = 8'h00;
        endcase
    end

    // ==========================================================
    // Registers
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            power_q        <= `RST_POWER;
            irq_general_q  <= `RST_IRQ_GENERAL;
            change_cfg_q   <= `RST_CHANGE_CFG;
            global_q       <= `RST_GLOBAL;
            misc_3v3_q     <= `RST_MISC1;
            change_q       <= 4'h0;
            detect_prev_q  <= 2'h3;
            ready_prev_q   <= 1'b0;
            battery_prev_q <= 2'h3;
            rdata_q        <= 8'h00;
        end else begin
            if (wr) begin
                case (index)
                    `IDX_POWER:       power_q       <= wdata;
                    `IDX_IRQ_GENERAL: irq_general_q <= wdata;
                    `IDX_CHANGE_CFG:  change_cfg_q  <= wdata;
                    `IDX_GLOBAL:      global_q      <= wdata & `GLB_RW_MASK;
                    `IDX_MISC1:       misc_3v3_q    <= wdata[`MISC_3V3_BIT];
                    default:          power_q       <= power_q;
                endcase
            end
            change_q       <= change_d;
            detect_prev_q  <= detect_now;
            ready_prev_q   <= ready_or_irq_in;
            battery_prev_q <= battery_now;
            rdata_q        <= rd ? rdata_d : 8'h00;
        end
    end

    // ==========================================================
    // Card-side outputs, all registered
    wire [15:0] func_irq = irq_onehot(irq_general_q[`IGC_STEER_LSB +: 4],
                                      isa_irq_enable & io_mode & ~ready_or_irq_in);
    wire [3:0]  route    = change_cfg_q[`CFG_ROUTE_LSB +: 4];
    // [R17] Level held while any bit pending
    // [R19] One level, no fresh edge per event
    wire        change_any = |(change_d & mode_mask);
    wire [15:0] change_lines = irq_onehot(route, change_any);

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            card_outputs_drive_q  <= 1'b0;
            card_reset_q          <= 1'b1;
            io_mode_q             <= 1'b0;
            supply_3v3_enable_n_q <= 1'b1;
            supply_5v_enable_n_q  <= 1'b1;
            prog_volt_enable0_q   <= 1'b0;
            prog_volt_enable1_q   <= 1'b0;
            ring_output_n_q       <= 1'b1;
            system_irq_line_q     <= 16'h0000;
            change_inta_q         <= 1'b0;
            change_irq_q          <= 1'b0;
        end else begin
            // [R8] Drive enable for card outputs
            card_outputs_drive_q  <= power_q[`PWR_DRIVE_BIT];
            // [R12] Reset held while bit is zero
            card_reset_q          <= ~irq_general_q[`IGC_RESET_BIT];
            // [R13] Mode select
            io_mode_q             <= io_mode;
            supply_3v3_enable_n_q <= s3v3_n;
            supply_5v_enable_n_q  <= s5v_n;
            prog_volt_enable0_q   <= vpp0;
            prog_volt_enable1_q   <= vpp1;
            // [R11] Ring pass-through
            ring_output_n_q       <= (io_mode && ring_en) ? battery1_or_change_in : 1'b1;
            // [R14] Steered card interrupt
            system_irq_line_q     <= func_irq | change_lines;
            change_inta_q         <= change_any & ~irq_code_valid(route);
            // [R17] Pending level
            change_irq_q          <= change_any;
        end
    end

endmodule
`default_nettype wire

// ==== card16_card_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ====================================
// Card in the socket, state set by the bench
// cs: function irq, change, seated b/a, ready, protect, battery 2/1
module card16_card_model (
    input  wire logic       io_mode,
    input  wire logic       in_reset,
    input  wire logic [7:0] cs,
    output logic            detect_pin_a_n,
    output logic            detect_pin_b_n,
    output logic            ready_or_irq_in,
    output logic            protect_or_width_in,
    output logic            battery1_or_change_in,
    output logic            battery2_in
);
    // Socket lines are pulled up, so an empty socket reads high
    wire logic gone = cs[5:4] == 2'b00;
    assign detect_pin_a_n = ~cs[4];
    assign detect_pin_b_n = ~cs[5];
    // A card held in reset stays busy
    assign ready_or_irq_in = gone | (io_mode ? ~cs[7] : cs[3] & ~in_reset);
    assign protect_or_width_in = gone | cs[2];
    assign battery1_or_change_in = gone | (io_mode ? ~cs[6] : cs[0]);
    assign battery2_in = gone | cs[1];
endmodule
`default_nettype wire

// ==== card16_socket_setup_regs_props.sv ====
`timescale 1ns/100ps
`default_nettype none
// ====================================
// Port-level checks
module card16_socket_setup_regs_props #(
    parameter [3:0] REVISION = 4'h1
) (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic [13:0] addr,
    input wire logic [7:0]  wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [7:0]  rdata_q,
    input wire logic        detect_pin_a_n,
    input wire logic        detect_pin_b_n,
    input wire logic        ready_or_irq_in,
    input wire logic        protect_or_width_in,
    input wire logic        detect_event_clear,
    input wire logic        card_outputs_drive_q,
    input wire logic        card_reset_q,
    input wire logic        io_mode_q,
    input wire logic        change_irq_q
);
    wire logic [11:0] idx = addr[13:2];
    wire logic [1:0]  det_n = {detect_pin_b_n, detect_pin_a_n};
    wire logic [1:0]  lvl = {ready_or_irq_in, protect_or_width_in};
    wire logic        w7 = wdata[7];
    wire logic        w6 = wdata[6];
    wire logic        w5 = wdata[5];
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    kind_field_a: assert property (rd && idx == 12'h800 |=> rdata_q[7:6] == 2'b10)
        else $error("interface kind wrong");
    rev_field_a: assert property (rd && idx == 12'h800 |=> rdata_q[5:0] == {2'b00, REVISION})
        else $error("revision field wrong");
    detect_invert_a: assert property (rd && idx == 12'h801 |=> rdata_q[3:2] == ~$past(det_n))
        else $error("detect bits not inverted");
    level_mirror_a: assert property (rd && idx == 12'h801 && !io_mode_q |=> rdata_q[5:4] == $past(lvl))
        else $error("ready or protect bit wrong");
    drive_write_a: assert property ($changed(card_outputs_drive_q) |->
        $past(wr, 2) && $past(idx, 2) == 12'h802 && card_outputs_drive_q == $past(w7, 2))
        else $error("output drive changed without write");
    card_reset_a: assert property ($changed(card_reset_q) |->
        $past(wr, 2) && $past(idx, 2) == 12'h803 && card_reset_q == !$past(w6, 2))
        else $error("card reset changed without write");
    mode_write_a: assert property ($changed(io_mode_q) |->
        $past(wr, 2) && $past(idx, 2) == 12'h803 && io_mode_q == $past(w5, 2))
        else $error("card mode changed without write");
    // Clears reach the level one edge after the strobe, enable or mode writes two
    irq_hold_a: assert property ($fell(change_irq_q) |->
        $past(rd) || $past(wr) || $past(wr, 2) || $past(detect_event_clear))
        else $error("change interrupt dropped without clear");
endmodule

bind card16_socket_setup_regs card16_socket_setup_regs_props #(.REVISION(REVISION)) props_i (
    .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
    .detect_pin_a_n(detect_pin_a_n), .detect_pin_b_n(detect_pin_b_n), .ready_or_irq_in(ready_or_irq_in),
    .protect_or_width_in(protect_or_width_in), .detect_event_clear(detect_event_clear),
    .card_outputs_drive_q(card_outputs_drive_q), .card_reset_q(card_reset_q), .io_mode_q(io_mode_q),
    .change_irq_q(change_irq_q));
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; $display("unexpected %s exp %0h got %0h", n, e, g); end end
module tb;
    // Arbitrary revision code
    localparam logic [3:0] REV = 4'hA;
    logic             clk, resetn, wr, rd, isa, dclr;
    logic [13:0]      addr;
    logic [7:0]       wdata, cs, p;
    logic [31:0]      seed;
    int               bad_count, cmp_count;
    wire logic        det_a_n, det_b_n, rdy_in, wp_in, bat1_in, bat2_in, drive, crst, io_mode;
    wire logic        s3_n, s5_n, v0, v1, ring_n, inta, chg_irq;
    wire logic [7:0]  rdata_q;
    wire logic [15:0] irq_lines;
    card16_socket_setup_regs #(.REVISION(REV)) card16_socket_setup_regs_i (
        .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
        .detect_pin_a_n(det_a_n), .detect_pin_b_n(det_b_n), .ready_or_irq_in(rdy_in),
        .protect_or_width_in(wp_in), .battery1_or_change_in(bat1_in), .battery2_in(bat2_in),
        .isa_irq_enable(isa), .detect_event_clear(dclr), .card_outputs_drive_q(drive), .card_reset_q(crst),
        .io_mode_q(io_mode), .supply_3v3_enable_n_q(s3_n), .supply_5v_enable_n_q(s5_n),
        .prog_volt_enable0_q(v0), .prog_volt_enable1_q(v1), .ring_output_n_q(ring_n),
        .system_irq_line_q(irq_lines), .change_inta_q(inta), .change_irq_q(chg_irq));
    card16_card_model card16_card_model_i (.io_mode(io_mode), .in_reset(crst), .cs(cs),
        .detect_pin_a_n(det_a_n), .detect_pin_b_n(det_b_n), .ready_or_irq_in(rdy_in),
        .protect_or_width_in(wp_in), .battery1_or_change_in(bat1_in), .battery2_in(bat2_in));
    // ====================================
    // Expectations and bus tasks
    function automatic [31:0] xs(input [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic [3:0] pwr_exp(input [7:0] v, input m);
        if (!v[4]) return 4'b1100;
        return {~m, m, v[1] & ~v[0], v[0]};
    endfunction
    function automatic [7:0] stat_exp(input [5:0] c, input pon);
        logic o;
        o = c[5:4] == 2'b00;
        return {1'b0, pon, c[3] | o, c[2] | o, c[5:4], c[1:0] | {2{o}}};
    endfunction
    task automatic wreg(input [11:0] i, input [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= {i, seed[1:0]};
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic chkr(input string n, input [11:0] i, input [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= {i, 2'b00};
        @(posedge clk);
        rd <= 1'b0;
        #1 `CHK(n, e, rdata_q)
    endtask
    task automatic card(input [7:0] v);
        @(posedge clk);
        cs <= v;
    endtask
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ====================================
    // Clock, watchdog and tests
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #20000;
        bad_count++;
        give_verdict;
    end
    initial begin
        {resetn, wr, rd, addr, wdata, dclr, p} = '0;
        isa = 1'b1;
        cs = 8'h3F;
        seed = 32'h10;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1 `CHK("reset outputs", 6'b011100, {drive, crst, s3_n, s5_n, v1, v0})
        wreg(12'h800, 8'hFF);
        chkr("identity", 12'h800, {4'h8, REV});
        wreg(12'h806, 8'hFF);
        chkr("unmapped", 12'h806, 8'h00);
        $display("test done: reset and identity");
        // Release card reset first, a card held in reset reports busy
        wreg(12'h803, 8'h40);
        for (int i = 0; i < 32; i++) begin
            seed = xs(seed);
            p = {i[4], seed[6:5], i[3], seed[3:2], i[1:0]};
            wreg(12'h82F, {7'h00, i[2]});
            wreg(12'h802, p);
            settle;
            `CHK("power pins", pwr_exp(p, i[2]), {s3_n, s5_n, v1, v0})
            `CHK("output drive", p[7], drive)
            chkr("power flag", 12'h801, stat_exp(cs[5:0], p[4]));
        end
        $display("test done: power control");
        settle;
        `CHK("card reset", 1'b0, crst)
        for (int i = 0; i < 12; i++) begin
            seed = xs(seed);
            card({2'b00, seed[5:0]});
            settle;
            chkr("status", 12'h801, stat_exp(seed[5:0], p[4]));
        end
        $display("test done: status");
        card(8'h33);
        settle;
        wreg(12'h805, 8'h0F);
        wreg(12'h81E, 8'h00);
        card(8'h3B);
        card(8'h39);
        card(8'h38);
        card(8'h28);
        settle;
        `CHK("irq pending", 2'b11, {chg_irq, inta})
        chkr("events", 12'h804, 8'h0F);
        chkr("read clear", 12'h804, 8'h00);
        settle;
        `CHK("irq released", 2'b00, {chg_irq, inta})
        wreg(12'h805, 8'h07);
        card(8'h38);
        settle;
        chkr("disabled", 12'h804, 8'h00);
        wreg(12'h805, 8'h0F);
        wreg(12'h81E, 8'h04);
        card(8'h28);
        card(8'h29);
        settle;
        chkr("no read clear", 12'h804, 8'h0A);
        wreg(12'h804, 8'h08);
        settle;
        `CHK("irq one left", 1'b1, chg_irq)
        chkr("write clear", 12'h804, 8'h02);
        wreg(12'h804, 8'h02);
        settle;
        `CHK("irq all clear", 1'b0, chg_irq)
        card(8'h39);
        settle;
        @(posedge clk) dclr <= 1'b1;
        @(posedge clk) dclr <= 1'b0;
        settle;
        chkr("event flag clear", 12'h804, 8'h00);
        $display("test done: change events");
        wreg(12'h803, 8'h65);
        card(8'hF9);
        settle;
        `CHK("steered irq", 16'h0020, irq_lines)
        @(posedge clk) isa <= 1'b0;
        settle;
        `CHK("steering off", 16'h0000, irq_lines)
        card(8'h39);
        settle;
        chkr("io events", 12'h804, 8'h01);
        wreg(12'h805, 8'h9F);
        settle;
        `CHK("change route", 17'h00200, {inta, irq_lines})
        wreg(12'h804, 8'h01);
        wreg(12'h803, 8'hE5);
        card(8'h79);
        settle;
        `CHK("ring out", 1'b0, ring_n)
        chkr("ring masks change", 12'h804, 8'h00);
        $display("test done: card mode");
        give_verdict;
    end
endmodule
`default_nettype wire
